// ### flash_rww_ctrl.sv
// Self-programming flash sequencer with concurrent-read gating
//
// Behaviour
// - Flash split into application and loader regions
// - Loader boundary follows the boot size fuses
// - Stores refused unless issued from loader code
// - Loader stores may target any page
// - Fixed concurrent/stalled split at constant address
// - Concurrent-region programming keeps CPU running
// - Stalled-region programming halts CPU, no reads
// - Loader region always inside stalled region
// - Busy flag reads one while region blocked
// - Separate lock sets for both regions
// - Pages only matter for programming
// - Busy set when concurrent programming starts
// - Busy cleared by read enable or load
// - Application lock bits gate stores and reads
`timescale 1ns/100ps
`default_nettype none
module flash_rww_ctrl
    import flash_rww_pkg::*;
#(
    parameter int ADDR_W = 14,
    parameter int PAGE_BITS = 6,
    parameter int LOADER_MIN = 256,
    parameter int STALLED_WORDS = 2048
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    // Avalon-MM register slave
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Fuse pins
    input wire logic [FUSE_W-1:0] BOOT_SIZE_FUSES_I,
    // Program operations from the core
    input wire logic OP_VALID_I,
    input wire logic [1:0] OP_KIND_I,
    input wire logic [ADDR_W-1:0] OP_PC_I,
    input wire logic [ADDR_W-1:0] OP_ADDR_I,
    output logic OP_DONE_O,
    output logic OP_REFUSED_O,
    // Program reads and fetches from the core
    input wire logic READ_REQ_I,
    input wire logic [ADDR_W-1:0] READ_ADDR_I,
    input wire logic [ADDR_W-1:0] CPU_PC_I,
    output logic READ_OK_O,
    output logic READ_DENY_O,
    // Interrupt gating
    input wire logic VEC_IN_LOADER_I,
    output logic INT_BLOCK_O,
    // Flash array control
    output logic FLASH_ERASE_O,
    output logic FLASH_WRITE_O,
    output logic [ADDR_W-1:0] FLASH_ADDR_O,
    input wire logic FLASH_DONE_I,
    // Core halt and busy flag
    output logic CPU_HALT_O,
    output logic CONC_BUSY_O
);
    localparam int AW1 = ADDR_W + 1;
    // Top of flash, one past the last word
    localparam logic [AW1-1:0] TOP = AW1'(2 ** ADDR_W);
    localparam logic [AW1-1:0] STALL_BASE = AW1'(2 ** ADDR_W - STALLED_WORDS);

    // Refuse shapes the decode cannot serve
    generate
        if (LOADER_MIN * (2 ** (2 ** FUSE_W - 1)) > STALLED_WORDS) begin : g_bad_ldr
            $error("Largest loader exceeds stalled region");
        end
        if (STALLED_WORDS >= 2 ** ADDR_W || PAGE_BITS >= ADDR_W) begin : g_bad_map
            $error("Region or page size does not fit flash");
        end
    endgenerate
    typedef enum logic [1:0] {
        IDLE,
        RUN_CONC,
        RUN_STALL
    } st_t;

    // Reset synchroniser
    logic rst_meta_q;
    logic rst_n_q;
    // Fuse synchroniser
    logic [FUSE_W-1:0] fuse_meta_q;
    logic [FUSE_W-1:0] fuse_q;
    // Sequencer state
    st_t st_q;
    st_t st_d;
    // Busy flag and halt
    logic busy_q;
    logic halt_q;
    // Lock bits, one set per region
    logic [3:0] lock_q;
    // Last operation was refused
    logic refused_q;
    // Bus handshake
    logic wait_q;
    logic [31:0] rdata_q;
    // Reset release through two flops
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Fuse pins are static but asynchronous
    always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fuse_meta_q <= '1;
            fuse_q <= '1;
        end else begin
            fuse_meta_q <= BOOT_SIZE_FUSES_I;
            fuse_q <= fuse_meta_q;
        end
    end

    // loader size doubles per step down in the fuse value
    wire [FUSE_W-1:0] shift_w = ~fuse_q;
    wire [AW1-1:0] ldr_words = AW1'(LOADER_MIN) << shift_w;
    wire [AW1-1:0] ldr_base = TOP - ldr_words;
    // region decode; base is an argument so callers track fuse changes
    function automatic logic in_ldr(input logic [ADDR_W-1:0] a, input logic [AW1-1:0] base);
        return {1'b0, a} >= base;
    endfunction
    function automatic logic in_conc(input logic [ADDR_W-1:0] a);
        return {1'b0, a} < STALL_BASE;
    endfunction
    // Operation checks
    wire op_from_ldr = in_ldr(OP_PC_I, ldr_base);
    wire tgt_ldr = in_ldr(OP_ADDR_I, ldr_base);
    wire tgt_conc = in_conc(OP_ADDR_I);
    wire is_load = OP_KIND_I == OP_LOAD;
    wire is_prog = OP_KIND_I == OP_ERASE || OP_KIND_I == OP_WRITE;
    // store lock picked by target region
    wire wr_locked = tgt_ldr ? !lock_q[LDR_LO] : !lock_q[APP_LO];
    // only loader code may start programming
    wire op_ok = op_from_ldr && (is_load || (is_prog && !wr_locked));
    wire op_take = OP_VALID_I && st_q == IDLE;
    wire prog_go = op_take && op_ok && is_prog;
    wire load_go = op_take && op_ok && is_load;
    wire op_bad = OP_VALID_I && !(op_take && op_ok);
    // Bus decode; writes land on the edge with waitrequest low
    wire acc = (AVS_READ_I || AVS_WRITE_I) && wait_q;
    wire wr0 = AVS_WRITE_I && !wait_q && AVS_BYTEENABLE_I[0];
    wire wr_ctrl = wr0 && AVS_ADDRESS_I == CTRL_OFS;
    wire wr_lock = wr0 && AVS_ADDRESS_I == LOCK_OFS;
    // Read enable only counts once programming is over
    wire rden_clr = wr_ctrl && AVS_WRITEDATA_I[RDEN_BIT] && st_q == IDLE;
    wire [31:0] ctrl_rd = 32'(busy_q) << BUSY_BIT;
    wire [31:0] lock_rd = {28'h0000000, lock_q};
    wire [31:0] stat_rd = {26'h0000000, fuse_q, refused_q, busy_q, st_q != IDLE, halt_q};
    wire [31:0] rd_mux = AVS_ADDRESS_I == CTRL_OFS ? ctrl_rd :
                         AVS_ADDRESS_I == LOCK_OFS ? lock_rd :
                         AVS_ADDRESS_I == STAT_OFS ? stat_rd : 32'h00000000;
    // Read checks
    wire rd_ldr = in_ldr(READ_ADDR_I, ldr_base);
    wire pc_ldr = in_ldr(CPU_PC_I, ldr_base);
    wire app_rd_lock = pc_ldr && !rd_ldr && !lock_q[APP_HI];
    wire ldr_rd_lock = !pc_ldr && rd_ldr && !lock_q[LDR_HI];
    // concurrent reads denied while busy, op untouched
    wire conc_blk = busy_q && in_conc(READ_ADDR_I);
    // no reads at all while halted
    wire rd_bad = halt_q || conc_blk || app_rd_lock || ldr_rd_lock;
    // vectors in the other region are masked once the running region's read lock bit is cleared
    wire int_blk_d = VEC_IN_LOADER_I ? (!pc_ldr && !lock_q[APP_HI]) : (pc_ldr && !lock_q[LDR_HI]);

    // Next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            IDLE: begin
                if (prog_go) begin
                    st_d = tgt_conc ? RUN_CONC : RUN_STALL;
                end
            end
            RUN_CONC,
            RUN_STALL: begin
                if (FLASH_DONE_I) begin
                    st_d = IDLE;
                end
            end
            default: begin
                st_d = IDLE;
            end
        endcase
    end

    // Sequencer and flags
    always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= IDLE;
            busy_q <= 1'b0;
            halt_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (prog_go && !tgt_conc) begin
                halt_q <= 1'b1;
            end else if (st_q == RUN_STALL && FLASH_DONE_I) begin
                halt_q <= 1'b0;
            end
            // busy set on concurrent start, set wins
            if (prog_go && tgt_conc) begin
                busy_q <= 1'b1;
            // cleared by read enable or page load
            end else if (rden_clr || load_go) begin
                busy_q <= 1'b0;
            end
            if (OP_VALID_I) begin
                refused_q <= op_bad;
            end
        end
    end

    // Flash strobes and page address
    always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            FLASH_ERASE_O <= 1'b0;
            FLASH_WRITE_O <= 1'b0;
            FLASH_ADDR_O <= '0;
        end else begin
            FLASH_ERASE_O <= prog_go && OP_KIND_I == OP_ERASE;
            FLASH_WRITE_O <= prog_go && OP_KIND_I == OP_WRITE;
            if (prog_go) begin
                FLASH_ADDR_O <= {OP_ADDR_I[ADDR_W-1:PAGE_BITS], PAGE_BITS'(0)};
            end
        end
    end
    // Answers to the core
    always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            OP_DONE_O <= 1'b0;
            READ_OK_O <= 1'b0;
            READ_DENY_O <= 1'b0;
            INT_BLOCK_O <= 1'b0;
        end else begin
            OP_DONE_O <= load_go || (st_q != IDLE && FLASH_DONE_I);
            READ_OK_O <= READ_REQ_I && !rd_bad;
            READ_DENY_O <= READ_REQ_I && rd_bad;
            INT_BLOCK_O <= int_blk_d;
        end
    end
    // Lock bits only go from unprogrammed to programmed
    always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lock_q <= LOCK_RST;
        end else if (wr_lock) begin
            lock_q <= lock_q & AVS_WRITEDATA_I[3:0];
        end
    end

    // Bus slave answers one cycle after a request
    always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= !acc;
            if (acc && AVS_READ_I) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign AVS_READDATA_O = rdata_q;
    assign AVS_WAITREQUEST_O = wait_q;
    assign OP_REFUSED_O = refused_q;
    assign CPU_HALT_O = halt_q;
    assign CONC_BUSY_O = busy_q;
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!rst_n_q);
    // Application code never starts programming
    app_store_refused_a: assert property (
        OP_VALID_I && !op_from_ldr |=> OP_REFUSED_O && !FLASH_ERASE_O && !FLASH_WRITE_O)
        else $error("Store from application code was not refused");
    // Loader stores reach loader pages too
    loader_self_prog_a: assert property (
        op_take && op_from_ldr && tgt_ldr && OP_KIND_I == OP_ERASE && lock_q[LDR_LO]
        |=> FLASH_ERASE_O && CPU_HALT_O)
        else $error("Loader erase of own page not started");
    // Loader always sits in the stalled region
    loader_in_stall_a: assert property (
        ldr_base >= STALL_BASE)
        else $error("Loader region reaches concurrent region");
    // Halt holds until flash completes
    stall_halt_a: assert property (
        st_q == RUN_STALL && !FLASH_DONE_I |=> CPU_HALT_O && !READ_OK_O)
        else $error("CPU not halted during stalled programming");
    // Concurrent start raises busy, no halt
    busy_set_a: assert property (
        prog_go && tgt_conc |=> CONC_BUSY_O && !CPU_HALT_O ##1 CONC_BUSY_O)
        else $error("Busy not set on concurrent programming");
    // Page load clears busy
    busy_load_clr_a: assert property (
        load_go |=> !CONC_BUSY_O && OP_DONE_O)
        else $error("Page load did not clear busy");
    // Blocked concurrent read denied, op continues
    conc_read_deny_a: assert property (
        READ_REQ_I && busy_q && in_conc(READ_ADDR_I) && st_q == RUN_CONC && !FLASH_DONE_I
        |=> READ_DENY_O && !READ_OK_O && st_q == RUN_CONC)
        else $error("Concurrent read while busy not denied");
    // Halt released right after completion
    halt_release_a: assert property (
        st_q == RUN_STALL && FLASH_DONE_I |=> !CPU_HALT_O && OP_DONE_O && st_q == IDLE)
        else $error("Halt not released after completion");
    // Application store lock refuses writes
    app_lock_wr_a: assert property (
        OP_VALID_I && !tgt_ldr && is_prog && !lock_q[APP_LO] |=> OP_REFUSED_O && !FLASH_WRITE_O)
        else $error("Locked application store not refused");
endmodule
`default_nettype wire

// ### flash_rww_pkg.sv
// Constants shared by the self-programming flash controller
package flash_rww_pkg;
    // Register byte offsets on the bus
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] LOCK_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    // Control register fields
    localparam int BUSY_BIT = 6;
    localparam int RDEN_BIT = 4;
    // Lock register fields
    localparam int APP_LO = 0;
    localparam int APP_HI = 1;
    localparam int LDR_LO = 2;
    localparam int LDR_HI = 3;
    localparam logic [3:0] LOCK_RST = 4'hF;
    // Operation kinds from the core
    localparam logic [1:0] OP_ERASE = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_LOAD = 2'h3;
    // Boot size fuse width
    localparam int FUSE_W = 2;
endpackage

// ### flash_array_model.sv
// Behavioural flash array: answers each start pulse with one done pulse
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Start pulses and answer delay
    input wire logic erase_i,
    input wire logic write_i,
    input wire logic [7:0] delay_i,
    output logic done_o
);
    // Cycles left in the running page operation
    int left;
    // Count down from a start; a zero delay still takes one cycle
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left <= 0;
            done_o <= 1'b0;
        end else begin
            done_o <= (left == 1);
            if (erase_i || write_i) begin
                left <= (delay_i == 8'h00) ? 1 : delay_i;
            end else if (left > 0) begin
                left <= left - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the self-programming flash controller
`timescale 1ns/100ps
`default_nettype none
// Compare two values, count, report a mismatch at once
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("Error %s exp %0h got %0h", n, e, g); end end
module tb;
    import flash_rww_pkg::*;
    // Stimulus
    logic clk, rst_n, rd, wr, opv, rq, vec;
    logic [1:0] fuse, kind;
    logic [3:0] adr, be;
    logic [7:0] dly;
    logic [13:0] pc, tad, raddr, cpc, fad;
    logic [31:0] wd, rdo, q;
    // Design outputs
    logic wreq, done, refd, rok, rdeny, intb, fer, fwr, fdone, halt, busy;
    // Model state: locks, fuses, busy and halt
    int errors = 0, check_count = 0, lockm = 15, fz = 0, f;
    logic bm = 1'b0, hm = 1'b0;
    flash_rww_ctrl u_dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdo), .AVS_WAITREQUEST_O(wreq),
        .BOOT_SIZE_FUSES_I(fuse), .OP_VALID_I(opv), .OP_KIND_I(kind), .OP_PC_I(pc), .OP_ADDR_I(tad),
        .OP_DONE_O(done), .OP_REFUSED_O(refd), .READ_REQ_I(rq), .READ_ADDR_I(raddr), .CPU_PC_I(cpc),
        .READ_OK_O(rok), .READ_DENY_O(rdeny), .VEC_IN_LOADER_I(vec), .INT_BLOCK_O(intb), .FLASH_ERASE_O(fer),
        .FLASH_WRITE_O(fwr), .FLASH_ADDR_O(fad), .FLASH_DONE_I(fdone), .CPU_HALT_O(halt), .CONC_BUSY_O(busy));
    flash_array_model u_flash (.clk_i(clk), .rst_n_i(rst_n), .erase_i(fer), .write_i(fwr), .delay_i(dly),
        .done_o(fdone));
    // Loader start word for the current fuses
    function automatic int lb();
        return 16384 - (256 << (~fz & 3));
    endfunction
    // Expected read grant from halt, busy and both read locks
    function automatic logic rexp(int a, int p);
        return !hm && !(bm && a < 14336) && !(!lockm[APP_HI] && p >= lb() && a < lb())
            && !(!lockm[LDR_HI] && p < lb() && a >= lb());
    endfunction
    // Verdict and end of run
    task automatic results();
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Avalon cycle held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        if (n == 20) begin
            errors++;
            results();
        end
        q = rdo;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // One fetch, answered by a pulse one cycle later
    task automatic fetch(input int a, input int p);
        @(posedge clk);
        rq <= 1'b1;
        raddr <= a[13:0];
        cpc <= p[13:0];
        @(posedge clk);
        rq <= 1'b0;
        @(negedge clk);
        `CHK("read ok", rexp(a, p), rok)
        `CHK("read deny", !rexp(a, p), rdeny)
    endtask
    // Program operation; blocked reads are tried while the page runs
    task automatic op(input logic [1:0] k, input int p, input int t);
        int n;
        logic xr, sh;
        xr = k == 2'h0 || p < lb() || (k != OP_LOAD && (t < lb() ? !lockm[APP_LO] : !lockm[LDR_LO]));
        sh = t >= 14336;
        @(posedge clk);
        opv <= 1'b1;
        kind <= k;
        pc <= p[13:0];
        tad <= t[13:0];
        @(posedge clk);
        opv <= 1'b0;
        @(negedge clk);
        `CHK("refused", xr, refd)
        if (xr || k == OP_LOAD) begin
            bm = bm && xr;
            `CHK("no start", 1'b0, fer | fwr)
            `CHK("load done", !xr, done)
            `CHK("busy", bm, busy)
        end else begin
            hm = sh;
            bm = bm || !sh;
            `CHK("start", {k == OP_WRITE, k == OP_ERASE}, {fwr, fer})
            `CHK("page", t[13:0] & 14'h3FC0, fad)
            `CHK("halt", sh, halt)
            `CHK("busy", bm, busy)
            // first fetch runs from the stalled region; next fetch, run from the concurrent region, probes denial
            n = 14336 + $urandom % 2048;
            fetch(n, n);
            n = $urandom % 14336;
            fetch(n, n);
            for (n = 0; n < 200 && done !== 1'b1; n++) @(negedge clk);
            if (n == 200) begin
                errors++;
                results();
            end
            hm = 1'b0;
            `CHK("halt off", 1'b0, halt)
        end
    endtask
    // Free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Main sequence
    initial begin
        {rd, wr, opv, rq, vec, fuse, kind, adr, wd, pc, tad, raddr, cpc} = '0;
        rst_n = 1'b0;
        dly = 8'h10;
        be = 4'hF;
        void'($urandom(51351));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, LOCK_OFS, 0);
        `CHK("lock reset", 32'hF, q)
        bus(1'b0, 4'hC, 0);
        `CHK("unmapped", 32'h0, q)
        `CHK("int free", 1'b0, intb)
        op(2'h0, 16383, 16383);
        // Every fuse setting moves the loader boundary
        for (f = 0; f < 4; f++) begin
            @(posedge clk);
            fz = f;
            fuse <= f[1:0];
            dly <= 12 + $urandom % 20;
            repeat (4) @(posedge clk);
            bus(1'b0, STAT_OFS, 0);
            `CHK("status", {f[1:0], 3'h0}, {q[5:4], q[2:0]})
            op(OP_ERASE, lb() - 1, 16383);
            op(f[0] ? OP_ERASE : OP_WRITE, lb(), lb());
            op(OP_WRITE, lb() + $urandom % (16384 - lb()), $urandom % 14336);
            op(OP_LOAD, lb(), 0);
            op(OP_ERASE, 16383, $urandom % 14336);
            bus(1'b0, CTRL_OFS, 0);
            `CHK("ctrl busy", 1'b1, q[BUSY_BIT])
            // Busy cleared by software before touching the region again
            bus(1'b1, CTRL_OFS, 32'h1 << RDEN_BIT);
            bm = 1'b0;
            fetch($urandom % 14336, 0);
        end
        // Store locks on both regions; locks only ever clear
        bus(1'b1, LOCK_OFS, 32'hA);
        lockm = lockm & 32'hA;
        op(OP_WRITE, lb(), 100);
        op(OP_WRITE, lb(), lb());
        bus(1'b1, LOCK_OFS, 32'hF);
        bus(1'b0, LOCK_OFS, 0);
        `CHK("lock and", 32'hA, q)
        // Write without byte lane 0 is ignored
        be <= 4'hE;
        bus(1'b1, LOCK_OFS, 32'h0);
        be <= 4'hF;
        bus(1'b1, LOCK_OFS, 32'h8);
        lockm = lockm & 32'h8;
        bus(1'b0, LOCK_OFS, 0);
        `CHK("lock lane", 32'h8, q)
        fetch(200, lb());
        fetch(lb(), 200);
        @(posedge clk);
        vec <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("int block", 1'b1, intb)
        results();
    end
endmodule
`default_nettype wire
